// File: logic/pin_strapped_clock_config.sv
// Purpose: Strapped and software-set configuration of four PLLs and clock relation
// Assumes: Strap inputs synchronous to aclk and static in use
// Notes:   Outputs are PLL control levels, not clocks
// Notes on behaviour
// R1: PLL runs only while its select low
// R2: High select powers PLL down, no clock
// R3: One select for core and bus PLL
// R4: Core PLL feeds core or bus clock
// R5: USB PLL always multiplies by 4.8
// R6: PHY PLL x2 when low, x2.5 high
// R7: Fastbus: bus clock is core PLL clock
// R8: Async: core and bus PLLs independent
// R9: Async straps need core no slower than bus
// R10: Frequency from pins or software setting
// R11: Core code selects 166 down to 33MHz
// R12: Async bus code: 133 for 000..010
// R13: Fastbus ignores bus code; USB 48MHz
// R14: Relation codes 01 and 10 unused
// R15: Fastbus code 101 gives 66MHz bus
`timescale 1ns/1ps
`default_nettype none

module pin_strapped_clock_config
    import clk_cfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              core_bus_pll_select_n,
    input  wire logic              usb_pll_select_n,
    input  wire logic              phy_pll_select_n,
    input  wire logic [1:0]        clock_relation_code,
    input  wire logic [2:0]        core_freq_code,
    input  wire logic [2:0]        bus_freq_code,
    input  wire logic              phy_ratio_select,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    output var  pll_gate_s         core_pll_gate,
    output var  pll_gate_s         bus_pll_gate,
    output var  pll_gate_s         usb_pll_gate,
    output var  pll_gate_s         phy_pll_gate,
    output var  logic [2:0]        core_pll_code,
    output var  logic [2:0]        bus_pll_code,
    output var  logic              bus_clk_from_core,
    output var  logic [7:0]        core_clk_mhz,
    output var  logic [7:0]        bus_clk_mhz,
    output var  logic [7:0]        usb_mult_x10,
    output var  logic [7:0]        phy_mult_x10,
    output var  logic              relation_fault,
    output var  logic              speed_order_fault
);

    initial begin
        if (ADDR_W < 4 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 4 and 32");
        end
    end

    // Core PLL frequency per code
    function automatic logic [7:0] core_mhz_of(input logic [2:0] code);
        logic [7:0] f;
        f = MHZ_33;
        unique case (code)
            CODE_166: f = MHZ_166;
            CODE_150: f = MHZ_150;
            CODE_133: f = MHZ_133;
            CODE_125: f = MHZ_125;
            CODE_100: f = MHZ_100;
            CODE_66:  f = MHZ_66;
            CODE_50:  f = MHZ_50;
            CODE_33:  f = MHZ_33;
        endcase
        return f; // R11
    endfunction

    // Bus PLL tops out at 133MHz, so the two fastest codes fold onto it
    function automatic logic [7:0] bus_mhz_of(input logic [2:0] code);
        logic [7:0] f;
        f = MHZ_133;
        if (code > CODE_133) begin
            f = core_mhz_of(code);
        end
        return f; // R12
    endfunction

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return 8'(a) & 8'hFC;
    endfunction

    // Strap sampling
    strap_s strap_r;
    logic [31:0] ctrl_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_r <= STRAP_RESET;
        end else begin
            strap_r <= '{core_bus_pll_select_n, usb_pll_select_n, phy_pll_select_n,
                         clock_relation_code, core_freq_code, bus_freq_code,
                         phy_ratio_select};
        end
    end

    // Effective frequency selection
    logic       sw_mode;
    logic [2:0] core_code_eff;
    logic [2:0] bus_code_eff;
    logic       phy_ratio_eff;
    logic       fastbus;
    logic [7:0] core_mhz_nxt;
    logic [7:0] bus_mhz_nxt;

    always_comb begin
        sw_mode       = ctrl_r[CTRL_SW_MODE];
        core_code_eff = sw_mode ? ctrl_r[CTRL_CORE_LSB +: 3] : strap_r.core_code; // R10
        bus_code_eff  = sw_mode ? ctrl_r[CTRL_BUS_LSB +: 3]  : strap_r.bus_code;  // R10
        phy_ratio_eff = sw_mode ? ctrl_r[CTRL_PHY_BIT]       : strap_r.phy_ratio; // R10
        fastbus       = (strap_r.relation == REL_FASTBUS);
        core_mhz_nxt  = core_mhz_of(core_code_eff);
        // Fastbus shares one clock; code 101 thus yields 66MHz on the bus too
        bus_mhz_nxt   = fastbus ? core_mhz_nxt : bus_mhz_of(bus_code_eff); // R13 R15 R7
    end

    // Core PLL gate; shares its select pin with the bus PLL
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_pll_gate <= '{1'b0, 1'b1};
        end else begin
            core_pll_gate <= '{!strap_r.core_bus_sel_n, strap_r.core_bus_sel_n}; // R1 R2 R3
        end
    end

    // Bus PLL gate; never split from the core gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_pll_gate <= '{1'b0, 1'b1};
        end else begin
            bus_pll_gate <= '{!strap_r.core_bus_sel_n, strap_r.core_bus_sel_n}; // R1 R2 R3
        end
    end

    // USB PLL gate, own select pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_pll_gate <= '{1'b0, 1'b1};
        end else begin
            usb_pll_gate <= '{!strap_r.usb_sel_n, strap_r.usb_sel_n}; // R1 R2 R3
        end
    end

    // PHY PLL gate, own select pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_pll_gate <= '{1'b0, 1'b1};
        end else begin
            phy_pll_gate <= '{!strap_r.phy_sel_n, strap_r.phy_sel_n}; // R1 R2 R3
        end
    end

    // Clock routing and effective codes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_pll_code     <= CODE_33;
            bus_pll_code      <= CODE_33;
            bus_clk_from_core <= 1'b1;
        end else begin
            core_pll_code     <= core_code_eff; // R11
            bus_pll_code      <= bus_code_eff;  // R12
            bus_clk_from_core <= fastbus;       // R4 R7 R8
        end
    end

    // A stopped PLL reports zero, so software never sees a stale rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_mhz <= 8'h00;
            bus_clk_mhz  <= 8'h00;
        end else begin
            core_clk_mhz <= strap_r.core_bus_sel_n ? 8'h00 : core_mhz_nxt; // R2
            bus_clk_mhz  <= strap_r.core_bus_sel_n ? 8'h00 : bus_mhz_nxt;  // R2 R8
        end
    end

    // USB ratio is fixed; no code reaches it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_mult_x10 <= 8'h00;
        end else begin
            usb_mult_x10 <= strap_r.usb_sel_n ? 8'h00 : USB_MULT_X10; // R5 R13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_mult_x10 <= 8'h00;
        end else if (strap_r.phy_sel_n) begin
            phy_mult_x10 <= 8'h00; // R2
        end else begin
            phy_mult_x10 <= phy_ratio_eff ? PHY_MULT_HI_X10 : PHY_MULT_LO_X10; // R6
        end
    end

    // Straps outside the supported set are flagged, not corrected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            relation_fault <= 1'b0;
        end else begin
            relation_fault <= !fastbus && (strap_r.relation != REL_ASYNC); // R14
        end
    end

    // Equal rates are legal; only a slower core is flagged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_order_fault <= 1'b0;
        end else begin
            speed_order_fault <= (strap_r.relation == REL_ASYNC)
                                 && (core_mhz_nxt < bus_mhz_nxt); // R9
        end
    end

    // AXI4-Lite write channel
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_go;
    logic [31:0]       bmask;

    assign wr_go = aw_held_r && w_held_r && !bvalid;

    always_comb begin
        bmask = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{wstrb_r[i]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            awready <= !aw_held_r && !(awvalid && awready);
            wready  <= !w_held_r && !(wvalid && wready);
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_go && reg_index(awaddr_r) == OFS_CTRL) begin
            ctrl_r <= ((ctrl_r & ~bmask) | (wdata_r & bmask)) & CTRL_MASK; // R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            // Status words are read-only; writing them is an error
            bresp  <= (reg_index(awaddr_r) == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read channel
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (reg_index(araddr))
            OFS_CTRL:   rd_word = ctrl_r;
            OFS_STRAP:  rd_word = 32'(strap_r);
            OFS_STATUS: rd_word = {24'h00_0000,
                                   speed_order_fault,
                                   relation_fault,
                                   bus_clk_from_core,
                                   sw_mode,
                                   phy_pll_gate.run,
                                   usb_pll_gate.run,
                                   bus_pll_gate.run,
                                   core_pll_gate.run};
            OFS_FREQ:   rd_word = {phy_mult_x10, usb_mult_x10, bus_clk_mhz, core_clk_mhz};
            default:    rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule // pin_strapped_clock_config

`default_nettype wire

// File: logic/clk_cfg_pkg.sv
// Purpose: Shared constants and types for the strapped clock configuration block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Frequencies are held as whole MHz, ratios as tenths
package clk_cfg_pkg;

    // Clock relation codes
    localparam logic [1:0] REL_FASTBUS = 2'h0;
    localparam logic [1:0] REL_ASYNC   = 2'h3;

    // Frequency codes
    localparam logic [2:0] CODE_166 = 3'h0;
    localparam logic [2:0] CODE_150 = 3'h1;
    localparam logic [2:0] CODE_133 = 3'h2;
    localparam logic [2:0] CODE_125 = 3'h3;
    localparam logic [2:0] CODE_100 = 3'h4;
    localparam logic [2:0] CODE_66  = 3'h5;
    localparam logic [2:0] CODE_50  = 3'h6;
    localparam logic [2:0] CODE_33  = 3'h7;

    // Output frequencies in MHz
    localparam logic [7:0] MHZ_166 = 8'hA6;
    localparam logic [7:0] MHZ_150 = 8'h96;
    localparam logic [7:0] MHZ_133 = 8'h85;
    localparam logic [7:0] MHZ_125 = 8'h7D;
    localparam logic [7:0] MHZ_100 = 8'h64;
    localparam logic [7:0] MHZ_66  = 8'h42;
    localparam logic [7:0] MHZ_50  = 8'h32;
    localparam logic [7:0] MHZ_33  = 8'h21;
    localparam logic [7:0] MHZ_48  = 8'h30;

    // Multiplier ratios in tenths
    localparam logic [7:0] USB_MULT_X10    = 8'h30;
    localparam logic [7:0] PHY_MULT_LO_X10 = 8'h14;
    localparam logic [7:0] PHY_MULT_HI_X10 = 8'h19;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STRAP  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FREQ   = 8'h0C;

    // Control register fields
    localparam int CTRL_SW_MODE   = 0;
    localparam int CTRL_CORE_LSB  = 4;
    localparam int CTRL_BUS_LSB   = 8;
    localparam int CTRL_PHY_BIT   = 12;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_1771;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic run;
        logic power_down;
    } pll_gate_s;

    typedef struct packed {
        logic       core_bus_sel_n;
        logic       usb_sel_n;
        logic       phy_sel_n;
        logic [1:0] relation;
        logic [2:0] core_code;
        logic [2:0] bus_code;
        logic       phy_ratio;
    } strap_s;

    localparam strap_s STRAP_RESET = '{1'b1, 1'b1, 1'b1, REL_FASTBUS, CODE_33, CODE_33, 1'b0};

endpackage

// File: tb/strap_source.sv
// Purpose: Board strap model driving the configuration pins
// Assumes: Straps change only when the bench asks
// Notes:   Static levels, no clock of its own
`timescale 1ns/1ps
`default_nettype none
module strap_source
    import clk_cfg_pkg::*;
(
    input  wire strap_s     cfg,
    output var  logic       core_bus_pll_select_n,
    output var  logic       usb_pll_select_n,
    output var  logic       phy_pll_select_n,
    output var  logic [1:0] clock_relation_code,
    output var  logic [2:0] core_freq_code,
    output var  logic [2:0] bus_freq_code,
    output var  logic       phy_ratio_select
);
    assign core_bus_pll_select_n = cfg.core_bus_sel_n;
    assign usb_pll_select_n = cfg.usb_sel_n;
    assign phy_pll_select_n = cfg.phy_sel_n;
    // Undefined codes never reach the pins
    assign clock_relation_code = (cfg.relation == REL_ASYNC) ? REL_ASYNC : REL_FASTBUS;
    // Bench keeps core faster than bus in async
    assign core_freq_code = cfg.core_code;
    assign bus_freq_code = cfg.bus_code;
    assign phy_ratio_select = cfg.phy_ratio;
endmodule // strap_source
`default_nettype wire

// File: tb/pin_strapped_clock_config_props.sv
// Purpose: Port assertions for the strapped clock configuration block
// Assumes: Two edges from strap pin to output
// Notes:   Frequency checks hold in pin and software mode
`timescale 1ns/1ps
`default_nettype none
module clk_cfg_checker
    import clk_cfg_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        core_bus_pll_select_n,
    input wire logic        usb_pll_select_n,
    input wire logic        phy_pll_select_n,
    input wire logic [1:0]  clock_relation_code,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire pll_gate_s   core_pll_gate,
    input wire pll_gate_s   bus_pll_gate,
    input wire logic [2:0]  core_pll_code,
    input wire logic [2:0]  bus_pll_code,
    input wire logic        bus_clk_from_core,
    input wire logic [7:0]  core_clk_mhz,
    input wire logic [7:0]  bus_clk_mhz,
    input wire logic [7:0]  usb_mult_x10,
    input wire logic [7:0]  phy_mult_x10
);
    localparam logic [7:0] MHZ_T [8] = '{MHZ_166, MHZ_150, MHZ_133, MHZ_125,
                                         MHZ_100, MHZ_66, MHZ_50, MHZ_33};
    logic [1:0] up_r;
    logic       up;
    // Pipeline still holds reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    assign up = (up_r == 2'h3);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_b_wait;
        bvalid && !bready;
    endsequence
    chk_core_gate: assert property (up |->
        core_pll_gate.run == !$past(core_bus_pll_select_n, 2) && bus_pll_gate == core_pll_gate &&
        core_pll_gate.power_down == $past(core_bus_pll_select_n, 2)) else $error("gate wrong");
    chk_usb_mult: assert property (up |-> usb_mult_x10 ==
        ($past(usb_pll_select_n, 2) ? 8'h00 : USB_MULT_X10)) else $error("usb ratio wrong");
    chk_phy_off: assert property (up |->
        (phy_mult_x10 == 8'h00) == $past(phy_pll_select_n, 2)) else $error("phy ratio wrong");
    chk_relation_src: assert property (up |->
        bus_clk_from_core == ($past(clock_relation_code, 2) == REL_FASTBUS))
        else $error("bus clock source wrong");
    chk_fast_equal: assert property (up && bus_clk_from_core |->
        bus_clk_mhz == core_clk_mhz) else $error("fastbus clocks differ");
    chk_core_map: assert property (up && core_pll_gate.run |->
        core_clk_mhz == MHZ_T[core_pll_code]) else $error("core frequency wrong");
    chk_bus_map: assert property (up && bus_pll_gate.run && !bus_clk_from_core |->
        bus_clk_mhz == (bus_pll_code < 3'h3 ? MHZ_133 : MHZ_T[bus_pll_code]))
        else $error("bus frequency wrong");
    chk_b_answer: assert property (s_wr_both |-> ##2 bvalid)
        else $error("write response late");
    chk_b_hold: assert property (s_b_wait |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
endmodule // clk_cfg_checker
bind pin_strapped_clock_config clk_cfg_checker chk_i (.*);
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the strapped clock configuration block
// Assumes: Straps from the strap model, registers over AXI4-Lite
// Notes:   Waits cover the two-edge strap path
`timescale 1ns/1ps
`default_nettype none
module tb
    import clk_cfg_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, bus_clk_from_core;
    logic relation_fault, speed_order_fault;
    wire logic core_bus_pll_select_n, usb_pll_select_n, phy_pll_select_n, phy_ratio_select;
    wire logic [1:0] clock_relation_code;
    wire logic [2:0] core_freq_code, bus_freq_code;
    logic [7:0]  awaddr, araddr, core_clk_mhz, bus_clk_mhz, usb_mult_x10, phy_mult_x10;
    logic [2:0]  awprot, arprot, core_pll_code, bus_pll_code;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    pll_gate_s   core_pll_gate, bus_pll_gate, usb_pll_gate, phy_pll_gate;
    strap_s      cfg;
    int          err_count, check_count;
    logic [7:0]  mhz_t [8] = '{MHZ_166, MHZ_150, MHZ_133, MHZ_125, MHZ_100, MHZ_66, MHZ_50, MHZ_33};
    pin_strapped_clock_config dut (.*);
    strap_source sp (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic put(input strap_s s);
        @(posedge aclk);
        cfg <= s;
        repeat (4) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd_d = rdata;
        resp = rresp;
    endtask
    task automatic t_reset;
        rd(OFS_CTRL);
        chk(rd_d, 32'h0000_0000);
        rd(OFS_STRAP);
        chk(rd_d, 32'(cfg));
    endtask
    task automatic t_fast;
        for (int c = 0; c < 8; c++) begin
            put('{1'b0, 1'b0, 1'b0, REL_FASTBUS, 3'(c), 3'(7 - c), 1'b0});
            chk(32'({core_clk_mhz, bus_clk_mhz}), 32'({mhz_t[c], mhz_t[c]}));
            chk(32'({bus_clk_from_core, usb_mult_x10}), 32'({1'b1, USB_MULT_X10}));
        end
    endtask
    task automatic t_async;
        for (int b = 0; b < 8; b++) begin
            put('{1'b0, 1'b0, 1'b0, REL_ASYNC, CODE_166, 3'(b), 1'b1});
            chk(32'(core_clk_mhz), 32'(MHZ_166));
            chk(32'(bus_clk_mhz), 32'(b < 3 ? MHZ_133 : mhz_t[b]));
            chk(32'({bus_clk_from_core, phy_mult_x10}), 32'(PHY_MULT_HI_X10));
        end
        rd(OFS_FREQ);
        chk(rd_d, {PHY_MULT_HI_X10, USB_MULT_X10, MHZ_33, MHZ_166});
        chk(32'({relation_fault, speed_order_fault}), 32'h0000_0000);
    endtask
    task automatic t_power;
        put('{1'b1, 1'b1, 1'b1, REL_ASYNC, CODE_100, CODE_50, 1'b0});
        chk(32'({core_pll_gate, bus_pll_gate, usb_pll_gate, phy_pll_gate}), 32'h0000_0055);
        chk({core_clk_mhz, bus_clk_mhz, usb_mult_x10, phy_mult_x10}, 32'h0000_0000);
        put('{1'b1, 1'b1, 1'b0, REL_ASYNC, CODE_100, CODE_50, 1'b0});
        chk(32'({core_pll_gate, bus_pll_gate, usb_pll_gate, phy_pll_gate}), 32'h0000_0056);
        chk(32'(phy_mult_x10), 32'(PHY_MULT_LO_X10));
        put('{1'b0, 1'b1, 1'b1, REL_ASYNC, CODE_100, CODE_50, 1'b0});
        chk(32'({core_pll_gate, bus_pll_gate, usb_pll_gate, phy_pll_gate}), 32'h0000_00a5);
        chk(32'({core_clk_mhz, bus_clk_mhz}), 32'({MHZ_100, MHZ_50}));
        rd(OFS_STATUS);
        chk(rd_d, 32'h0000_0003);
    endtask
    task automatic t_sw;
        put('{1'b0, 1'b0, 1'b0, REL_ASYNC, CODE_100, CODE_33, 1'b0});
        wr(OFS_CTRL, 32'h0000_1431);
        chk(32'(resp), 32'(RESP_OKAY));
        chk(32'({core_clk_mhz, bus_clk_mhz}), 32'({MHZ_125, MHZ_100}));
        chk(32'(phy_mult_x10), 32'(PHY_MULT_HI_X10));
        rd(OFS_CTRL);
        chk(rd_d, 32'h0000_1431);
        wr(OFS_STRAP, 32'hffff_ffff);
        chk(32'(resp), 32'(RESP_SLVERR));
        rd(8'h40);
        chk({rd_d[29:0], resp}, 32'(RESP_SLVERR));
        wr(OFS_CTRL, 32'h0000_0000);
        chk(32'({core_clk_mhz, bus_clk_mhz}), 32'({MHZ_100, MHZ_33}));
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        test_done;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, awprot, arprot, wdata} = 54'h0;
        wstrb = 4'hf;
        err_count = 0;
        check_count = 0;
        cfg = '{1'b0, 1'b0, 1'b0, REL_FASTBUS, CODE_133, CODE_50, 1'b0};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_fast;
        t_async;
        t_power;
        t_sw;
        test_done;
    end
endmodule // tb
`default_nettype wire
